// ==== hdl/gpp_port.sv ====
// Eight-pin general-purpose port with direction and level registers on the peripheral bus.
//
// What this block does
// - Eight individually steerable pins, pin 0 least significant, pin 7 most.
// - Both registers answer the shared peripheral bus used by core and DMA.
// - Direction register decodes at 0x3400, level register at 0x3401.
// - Pins 3 and 5 share pads with serial transmit clock and frame sync.
// - Top pin low at reset gives the shared pads to pins 3 and 5.
// - Top pin high at reset gives the shared pads to the serial transmitter.
// - The shared-pad choice is fixed at reset release and held afterwards.
// - Direction bits reset to zero; one means output, zero means input.
// - An input pin's level bit reads one when high, zero when low.
// - An output pin drives the level bit last written to it, except pins 3 and 5 in serial mode, which the transmitter drives.
// - After reset the level register shows the pins, not a constant.
`include "gpp_map.svh"
`default_nettype none

module gpp_port (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic PB_SEL,
	input wire logic PB_WR,
	input wire logic [15:0] PB_ADDR,
	input wire logic [15:0] PB_WDATA,
	output logic [15:0] PB_RDATA,
	output logic PB_ACK,
	input wire logic [7:0] GPIO_IN,
	output logic [7:0] GPIO_OUT,
	output logic [7:0] GPIO_OE,
	input wire logic SER_CLK_O,
	input wire logic SER_CLK_OE,
	input wire logic SER_FS_O,
	input wire logic SER_FS_OE,
	output logic SER_CLK_I,
	output logic SER_FS_I,
	output logic SERIAL_MODE
);
	gpp_pad_if pif ();

	gpp_pkg::gpp_regs_s r;
	gpp_pkg::gpp_regs_s next_r;
	logic hit_dir;
	logic hit_level;
	logic [7:0] level_view;

	// ----------------------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------------------
	gpp_strap u_gpp_strap (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.pads(pif.strap)
	);

	gpp_pads u_gpp_pads (
		.pin_in(GPIO_IN),
		.pin_out(GPIO_OUT),
		.pin_oe(GPIO_OE),
		.ser_clk_o(SER_CLK_O),
		.ser_clk_oe(SER_CLK_OE),
		.ser_fs_o(SER_FS_O),
		.ser_fs_oe(SER_FS_OE),
		.ser_clk_i(SER_CLK_I),
		.ser_fs_i(SER_FS_I),
		.pads(pif.pads)
	);

	// ----------------------------------------------------------------------------
	// Address decode and read view
	// ----------------------------------------------------------------------------
	// Core and DMA arrive through one bus controller, so one slave port serves both.
	assign hit_dir = PB_SEL && (PB_ADDR == `GPP_ADDR_DIR);
	assign hit_level = PB_SEL && (PB_ADDR == `GPP_ADDR_LEVEL);

	// Input pins show the live pad, output pins show the written level. There is
	// no stored reset value for inputs; the read always follows the pad.
	assign level_view = (r.dir & r.drive) | (~r.dir & pif.level);

	// ----------------------------------------------------------------------------
	// Register update and bus answer
	// ----------------------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.ack = PB_SEL;
		next_r.rdata = {`GPP_UPPER_ZERO, `GPP_UPPER_ZERO};
		if (PB_SEL && PB_WR) begin
			if (hit_dir) begin
				next_r.dir = PB_WDATA[7:0];
			end
			if (hit_level) begin
				next_r.drive = PB_WDATA[7:0];
			end
		end else if (PB_SEL) begin
			if (hit_dir) begin
				next_r.rdata = {`GPP_UPPER_ZERO, r.dir};
			end else if (hit_level) begin
				next_r.rdata = {`GPP_UPPER_ZERO, level_view};
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign pif.dir = r.dir;
	assign pif.drive = r.drive;
	assign PB_RDATA = r.rdata;
	assign PB_ACK = r.ack;
	assign SERIAL_MODE = pif.serial_mode;

	// ----------------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------------
	plain_pin_enable_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(GPIO_OE & `GPP_PLAIN_MASK) == (r.dir & `GPP_PLAIN_MASK))
		else $error("Plain pin enable does not follow its direction bit.");

	bus_answer_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		PB_SEL |=> PB_ACK ##1 (PB_ACK == $past(PB_SEL)))
		else $error("Bus answer not one cycle after select.");

	dir_write_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(PB_SEL && PB_WR && PB_ADDR == `GPP_ADDR_DIR) |=> (r.dir == $past(PB_WDATA[7:0])))
		else $error("Direction write at its address did not land.");

	unmapped_write_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(PB_SEL && PB_WR && PB_ADDR != `GPP_ADDR_DIR && PB_ADDR != `GPP_ADDR_LEVEL)
		|=> ($stable(r.dir) && $stable(r.drive)))
		else $error("Write elsewhere changed a port register.");

	shared_as_port_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(pif.strap_valid && !SERIAL_MODE) |-> (GPIO_OE[3] == r.dir[3] && GPIO_OUT[3] == r.drive[3]
		&& GPIO_OE[5] == r.dir[5] && GPIO_OUT[5] == r.drive[5]))
		else $error("Shared pads not given to port pins in port mode.");

	shared_as_serial_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(pif.strap_valid && SERIAL_MODE) |-> (GPIO_OE[3] == SER_CLK_OE && GPIO_OUT[3] == SER_CLK_O
		&& GPIO_OE[5] == SER_FS_OE && GPIO_OUT[5] == SER_FS_O))
		else $error("Shared pads not given to the serial transmitter.");

	strap_capture_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		$rose(pif.strap_valid) |-> (SERIAL_MODE == $past(GPIO_IN[7])))
		else $error("Strap did not take the top pin level at release.");

	dir_reset_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		!pif.strap_valid |-> (r.dir == `GPP_DIR_RESET && GPIO_OE == 8'h00))
		else $error("Direction not all inputs right after reset.");

	input_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(PB_SEL && !PB_WR && PB_ADDR == `GPP_ADDR_LEVEL)
		|=> (PB_RDATA[7:0] == (($past(r.dir) & $past(r.drive)) | (~$past(r.dir) & $past(GPIO_IN)))))
		else $error("Level read does not match pins and written levels.");

	output_drive_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(PB_SEL && PB_WR && PB_ADDR == `GPP_ADDR_LEVEL)
		|=> ((GPIO_OUT & `GPP_PLAIN_MASK) == ($past(PB_WDATA[7:0]) & `GPP_PLAIN_MASK)))
		else $error("Output pins do not drive the written level.");

	upper_zero_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		PB_ACK |-> (PB_RDATA[15:8] == `GPP_UPPER_ZERO))
		else $error("Upper register bits read nonzero.");

endmodule

`default_nettype wire

// ==== hdl/gpp_map.svh ====
// Address map, field positions, reset values and pin roles of the eight-pin general-purpose port.
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH

// ----------------------------------------------------------------------------
// Register addresses on the peripheral bus
// ----------------------------------------------------------------------------
`define GPP_ADDR_DIR 16'h3400
`define GPP_ADDR_LEVEL 16'h3401

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define GPP_PIN_COUNT 8
`define GPP_DIR_RESET 8'h00
`define GPP_DRIVE_RESET 8'h00
`define GPP_UPPER_ZERO 8'h00
`define GPP_RDATA_RESET 16'h0000

// ----------------------------------------------------------------------------
// Pin roles
// ----------------------------------------------------------------------------
`define GPP_STRAP_BIT 7
`define GPP_SHARED_CLK_BIT 3
`define GPP_SHARED_FS_BIT 5
`define GPP_PLAIN_MASK 8'hD7

`endif

// ==== hdl/gpp_pkg.sv ====
// Types shared by the eight-pin general-purpose port modules.
`default_nettype none

package gpp_pkg;

	// ----------------------------------------------------------------------------
	// Register-side state
	// ----------------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] drive;
		logic [15:0] rdata;
		logic ack;
	} gpp_regs_s;

	// ----------------------------------------------------------------------------
	// Strap capture state
	// ----------------------------------------------------------------------------
	typedef struct packed {
		logic taken;
		logic serial;
	} gpp_strap_s;

endpackage

`default_nettype wire

// ==== hdl/gpp_pad_if.sv ====
// Carrier between the register core, the strap capture and the pad multiplexer.
`default_nettype none

interface gpp_pad_if;
	logic [7:0] dir;
	logic [7:0] drive;
	logic [7:0] level;
	logic serial_mode;
	logic strap_valid;

	modport regs (output dir, output drive, input level, input serial_mode, input strap_valid);
	modport strap (input level, output serial_mode, output strap_valid);
	modport pads (input dir, input drive, output level, input serial_mode, input strap_valid);
endinterface

`default_nettype wire

// ==== hdl/gpp_strap.sv ====
// Capture of the shared-pad function from the top pin level at reset release.
`include "gpp_map.svh"
`default_nettype none

module gpp_strap (
	input wire logic clk,
	input wire logic rst_b,
	gpp_pad_if.strap pads
);
	gpp_pkg::gpp_strap_s r;
	gpp_pkg::gpp_strap_s next_r;

	// ----------------------------------------------------------------------------
	// Capture once, on the first edge after release
	// ----------------------------------------------------------------------------
	// The asynchronous reset may only load constants, so the pin is sampled on
	// the first clock after release; the direction register is still all inputs
	// then, so the top pin still carries the board's strap level.
	always_comb begin
		next_r = r;
		if (!r.taken) begin
			next_r.taken = 1'b1;
			next_r.serial = pads.level[`GPP_STRAP_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign pads.serial_mode = r.serial;
	assign pads.strap_valid = r.taken;

	strap_frozen_a: assert property (@(posedge clk) disable iff (!rst_b)
		$past(r.taken) |-> $stable(r.serial))
		else $error("Shared-pad function changed after it was fixed.");

endmodule

`default_nettype wire

// ==== hdl/gpp_pads.sv ====
// Pad multiplexer: port pins and the two pads shared with the serial transmitter.
`include "gpp_map.svh"
`default_nettype none

module gpp_pads (
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	input wire logic ser_clk_o,
	input wire logic ser_clk_oe,
	input wire logic ser_fs_o,
	input wire logic ser_fs_oe,
	output logic ser_clk_i,
	output logic ser_fs_i,
	gpp_pad_if.pads pads
);

	// ----------------------------------------------------------------------------
	// Per-pin output selection
	// ----------------------------------------------------------------------------
	// Shared pads stay undriven until the strap is known, so neither function can
	// fight the board during the first cycle after reset.
	for (genvar i = 0; i < `GPP_PIN_COUNT; i++) begin : g_pin
		if (i == `GPP_SHARED_CLK_BIT || i == `GPP_SHARED_FS_BIT) begin : g_shared
			logic ser_o;
			logic ser_oe;
			assign ser_o = (i == `GPP_SHARED_CLK_BIT) ? ser_clk_o : ser_fs_o;
			assign ser_oe = (i == `GPP_SHARED_CLK_BIT) ? ser_clk_oe : ser_fs_oe;
			assign pin_out[i] = pads.serial_mode ? ser_o : pads.drive[i];
			assign pin_oe[i] = pads.strap_valid & (pads.serial_mode ? ser_oe : pads.dir[i]);
		end else begin : g_plain
			assign pin_out[i] = pads.drive[i];
			assign pin_oe[i] = pads.dir[i];
		end
	end

	assign pads.level = pin_in;
	assign ser_clk_i = pads.serial_mode & pin_in[`GPP_SHARED_CLK_BIT];
	assign ser_fs_i = pads.serial_mode & pin_in[`GPP_SHARED_FS_BIT];

endmodule

`default_nettype wire

// ==== bench/gpp_board.sv ====
// Board model: external pad drivers and the serial transmitter beside the port.
`default_nettype none

module gpp_board (
	input wire logic clk,
	input wire logic [7:0] ext_level,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	output logic [7:0] pad,
	output logic ser_clk,
	output logic ser_fs,
	output logic ser_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	assign ser_oe = 1'b1;

	// The frame sync follows the clock a cycle late, so the two shared pads never carry the same pattern.
	// The identity compare lets the toggle start from an unknown value without a second driver.
	always @(posedge clk) begin
		ser_clk <= !(ser_clk === 1'b1);
		ser_fs <= (ser_clk === 1'b1);
	end

	// Each pad shows whoever drives it: the port when enabled, else the board's own level.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pad[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
		end
	end
endmodule

`default_nettype wire

// ==== bench/gpp_port_bench.sv ====
// Self-checking bench for the eight-pin general-purpose port.
`include "gpp_map.svh"
`default_nettype none

module gpp_port_bench;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic wr;
		logic [15:0] addr;
		logic [15:0] wd;
		logic [15:0] exp;
	} gpp_row_s;

	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic sel = 1'b0;
	logic wr = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic [7:0] ext = 8'h3C;
	logic [15:0] rdata;
	logic ack;
	logic [7:0] pad, pin_out, pin_oe;
	logic ser_clk_o, ser_fs_o, ser_oe, ser_clk_i, ser_fs_i, serial_mode;
	logic [15:0] rd;
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	gpp_row_s rows [0:9] = '{
		'{1'b1, 16'h3400, 16'h00FF, 16'h0000}, '{1'b1, 16'h3401, 16'h00A5, 16'h0000},
		'{1'b0, 16'h3401, 16'h0000, 16'h00A5}, '{1'b0, 16'h3400, 16'h0000, 16'h00FF},
		'{1'b1, 16'h3400, 16'hFF0F, 16'h0000}, '{1'b0, 16'h3400, 16'h0000, 16'h000F},
		'{1'b0, 16'h3401, 16'h0000, 16'h0035}, '{1'b1, 16'h3402, 16'h00FF, 16'h0000},
		'{1'b0, 16'h3402, 16'h0000, 16'h0000}, '{1'b0, 16'h3400, 16'h0000, 16'h000F}};

	gpp_port u_gpp_port (.CORE_CLK(clk), .RST_B(rst_b), .PB_SEL(sel), .PB_WR(wr), .PB_ADDR(addr),
		.PB_WDATA(wdata), .PB_RDATA(rdata), .PB_ACK(ack), .GPIO_IN(pad), .GPIO_OUT(pin_out),
		.GPIO_OE(pin_oe), .SER_CLK_O(ser_clk_o), .SER_CLK_OE(ser_oe), .SER_FS_O(ser_fs_o),
		.SER_FS_OE(ser_oe), .SER_CLK_I(ser_clk_i), .SER_FS_I(ser_fs_i), .SERIAL_MODE(serial_mode));

	gpp_board u_gpp_board (.clk(clk), .ext_level(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad),
		.ser_clk(ser_clk_o), .ser_fs(ser_fs_o), .ser_oe(ser_oe));

	initial begin
		forever #2 clk = ~clk;
	end

	// ----------------------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// One strobe cycle; the answer stands only in the following cycle, so it is read there.
	task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] r);
		@(posedge clk);
		sel <= 1'b1;
		wr <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		sel <= 1'b0;
		#1;
		check({15'h0000, ack}, 16'h0001);
		r = rdata;
	endtask

	task automatic do_reset;
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic tally_and_finish;
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------------------
	// Timeout and main sequence
	// ----------------------------------------------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			tally_and_finish();
		end
	end

	initial begin
		do_reset();
		check({8'h00, pin_oe}, 16'h0000);
		check({15'h0000, serial_mode}, 16'h0000);
		bus(1'b0, `GPP_ADDR_DIR, 16'h0000, rd);
		check(rd, 16'h0000);
		bus(1'b0, `GPP_ADDR_LEVEL, 16'h0000, rd);
		check(rd, 16'h003C);
		for (int i = 0; i < 10; i++) begin
			bus(rows[i].wr, rows[i].addr, rows[i].wd, rd);
			check(rd, rows[i].exp);
		end
		bus(1'b1, `GPP_ADDR_DIR, 16'h00FF, rd);
		bus(1'b1, `GPP_ADDR_LEVEL, 16'h007A, rd);
		check({pin_oe, pin_out}, 16'hFF7A);
		check({8'h00, pad}, 16'h007A);
		check({14'h0000, ser_clk_i, ser_fs_i}, 16'h0000);
		// Serial ownership is strapped by the top pin, then the strap is removed.
		@(posedge clk);
		ext <= 8'h80;
		do_reset();
		@(posedge clk);
		ext <= 8'h00;
		repeat (3) @(posedge clk);
		#1;
		check({15'h0000, serial_mode}, 16'h0001);
		check({8'h00, pin_oe}, 16'h0028);
		check({8'h00, pin_out & 8'h28}, {10'h000, ser_fs_o, 1'b0, ser_clk_o, 3'h0});
		check({14'h0000, ser_clk_i, ser_fs_i}, {14'h0000, pad[3], pad[5]});
		bus(1'b1, `GPP_ADDR_DIR, 16'h00FF, rd);
		check({15'h0000, serial_mode}, 16'h0001);
		tally_and_finish();
	end
endmodule

`default_nettype wire
